//--- rtl/hlmc_defines.vh
// Constants for the haptic loop mode control block
`ifndef HLMC_DEFINES_VH
`define HLMC_DEFINES_VH
// Clock and time bases
`define HLMC_CLK_HZ 40000000
`define HLMC_CLK_MHZ (`HLMC_CLK_HZ / 1000000)
`define HLMC_PWM_HZ 20500
`define HLMC_PWM_CYC (`HLMC_CLK_HZ / `HLMC_PWM_HZ)
`define HLMC_START_US 1000
`define HLMC_START_CYC (`HLMC_START_US * `HLMC_CLK_MHZ)
`define HLMC_OL_UNIT_NS 97560
`define HLMC_OL_UNIT_CYC (`HLMC_OL_UNIT_NS * `HLMC_CLK_MHZ / 1000)
`define HLMC_DT_UNIT_US 100
`define HLMC_DT_UNIT_CYC (`HLMC_DT_UNIT_US * `HLMC_CLK_MHZ)
// Register byte offsets
`define HLMC_OFS_CTRL 8'h00
`define HLMC_OFS_DRIVE 8'h04
`define HLMC_OFS_LEVEL 8'h08
`define HLMC_OFS_STATUS 8'h0c
`define HLMC_OFS_PERIOD 8'h10
// Control fields
`define HLMC_CTRL_TYPE 0
`define HLMC_CTRL_LATCH 1
`define HLMC_CTRL_ULIM 2
`define HLMC_CTRL_GO 4
`define HLMC_CTRL_MASK 32'h0000001f
`define HLMC_CTRL_RST 32'h00000000
// Drive timing fields
`define HLMC_DRV_OLP 0
`define HLMC_DRV_DT 8
`define HLMC_DRV_ZC 16
`define HLMC_DRV_BRK 20
`define HLMC_DRV_MASK 32'h00731f7f
`define HLMC_DRV_RST 32'h00100a29
// Level fields
`define HLMC_LVL_AMP 0
`define HLMC_LVL_RATED 8
`define HLMC_LVL_CLAMP 16
`define HLMC_LVL_MASK 32'h00ffffff
`define HLMC_LVL_RST 32'h00c08000
// Bus responses
`define HLMC_RESP_OKAY 2'b00
`define HLMC_RESP_SLVERR 2'b10
`endif

//--- rtl/hlmc_top.v
// Haptic actuator loop mode control with AXI4-Lite registers
// Operation
// [R1] Host selects actuator type before playback
// [R2] Resonance acquired within first half cycle
// [R3] Resonance estimate refreshed every half cycle
// [R4] Tracking independent of level calibration
// [R5] Resonant period readable, valid while synchronised
// [R6] Invalid back-EMF: open-loop overdrive, then resume
// [R7] Fallback half period from drive minus detect
// [R8] Latch open-loop only after sync failure
// [R9] Two-bit limit of tolerated unsynchronised cycles
// [R10] Latched open-loop: no overdrive, no braking
// [R11] Open-loop period is code times 97.56us
// [R12] Drive starts 1 ms after trigger
// [R13] Both outputs PWM at 20.5 kHz
// [R14] Closed loop adds overdrive and braking itself
// [R15] Startup boost raises loop gain
// [R16] Brake ratio scales braking versus driving gain
// [R17] Full-scale input gives rated level
// [R18] Output never exceeds overdrive clamp
// [R19] Shutdown pin low holds device off
// [R20] Mode changes only at cycle boundaries
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hlmc_defines.vh"

module hlmc_top #(
   parameter START_CYC = `HLMC_START_CYC,
   parameter BOOST_HALVES = 4,
   parameter BRAKE_HALVES = 4
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write channels
   input wire [7:0] awaddr,
   input wire awvalid,
   output wire awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   // AXI4-Lite read channels
   input wire [7:0] araddr,
   input wire arvalid,
   output wire arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   // Device pins
   input wire shutdown_n_pin,
   input wire bemf_sign_pin,
   input wire bemf_valid_pin,
   // Actuator drive
   output reg out_p,
   output reg out_n
);

   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_WAIT = 2'd1;
   localparam [1:0] ST_DRIVE = 2'd2;
   localparam [1:0] ST_BRAKE = 2'd3;
   // Full-width copies, cut to the counter widths on purpose
   localparam [31:0] PWM_CYC_W = `HLMC_PWM_CYC;
   localparam [31:0] START_W = START_CYC - 1;
   localparam [31:0] BOOST_W = BOOST_HALVES;
   localparam [31:0] BRAKE_W = BRAKE_HALVES;
   localparam [10:0] PWM_LAST = PWM_CYC_W[10:0] - 11'h001;
   localparam [15:0] START_LAST = START_W[15:0];
   localparam [7:0] BOOST_N = BOOST_W[7:0];
   localparam [7:0] BRAKE_N = BRAKE_W[7:0];

   // Gain scaling: (a+1)*r/256 so that a full-scale input yields r exactly
   function [7:0] scale8;
      input [7:0] a;
      input [7:0] r;
      reg [15:0] p;
      begin
         p = ({8'h00, a} + 16'h0001) * {8'h00, r};
         scale8 = p[15:8];
      end
   endfunction

   // Saturate a raised level at the clamp
   function [7:0] clamp8;
      input [10:0] x;
      input [7:0] c;
      begin
         if (x > {3'h0, c})
            clamp8 = c;
         else
            clamp8 = x[7:0];
      end
   endfunction

   // Time code times a cycle unit, cut to the timer width
   function [19:0] mul_unit;
      input [6:0] k;
      input [31:0] u;
      reg [31:0] p;
      begin
         p = {25'h0, k} * u;
         mul_unit = p[19:0];
      end
   endfunction

   // Byte-lane merge for write strobes
   function [31:0] merge;
      input [31:0] o;
      input [31:0] n;
      input [3:0] s;
      integer i;
      begin
         merge = o;
         for (i = 0; i < 4; i = i + 1)
            if (s[i])
               merge[8*i +: 8] = n[8*i +: 8];
      end
   endfunction

   reg sd_meta, sd_sync, bs_meta, bs_sync, bs_prev, bv_meta, bv_sync;
   reg [31:0] ctrl, drive, level;
   reg [1:0] state;
   reg [15:0] wait_cnt;
   reg [19:0] half_tmr;
   reg [20:0] period;
   reg [10:0] pwm_cnt, duty;
   reg [7:0] halves, brk_cnt;
   reg [2:0] unsync_cnt;
   reg pol, synced, latched, cl_mode, act_lra;
   reg bound, good, bad;
   reg [7:0] lvl;
   reg [31:0] rd_val;
   reg rd_err;

   // Register fields
   wire actuator_type_select = ctrl[`HLMC_CTRL_TYPE];
   wire latch_open_loop_enable = ctrl[`HLMC_CTRL_LATCH];
   wire [1:0] unsync_cycle_limit = ctrl[`HLMC_CTRL_ULIM +: 2];
   wire go = ctrl[`HLMC_CTRL_GO];
   wire [6:0] open_loop_period_code = drive[`HLMC_DRV_OLP +: 7];
   wire [4:0] drive_time = drive[`HLMC_DRV_DT +: 5];
   wire [1:0] zero_cross_detect_time = drive[`HLMC_DRV_ZC +: 2];
   wire [2:0] brake_gain_ratio = drive[`HLMC_DRV_BRK +: 3];
   wire [7:0] amp = level[`HLMC_LVL_AMP +: 8];
   wire [7:0] rated = level[`HLMC_LVL_RATED +: 8];
   wire [7:0] clampv = level[`HLMC_LVL_CLAMP +: 8];

   // Bus handshakes: write needs address and data together
   wire wr_go = awvalid & wvalid & ~bvalid;
   wire ar_go = arvalid & ~rvalid;
   assign awready = wr_go;
   assign wready = wr_go;
   assign arready = ar_go;
   wire wr_hit = (awaddr == `HLMC_OFS_CTRL) | (awaddr == `HLMC_OFS_DRIVE) |
      (awaddr == `HLMC_OFS_LEVEL) | (awaddr == `HLMC_OFS_STATUS) |
      (awaddr == `HLMC_OFS_PERIOD);

   // Half-period limits of both open-loop schedules
   wire [4:0] dt_diff = (drive_time > {3'h0, zero_cross_detect_time}) ?
      drive_time - {3'h0, zero_cross_detect_time} : 5'h01;
   wire [19:0] fb_half = mul_unit({2'h0, dt_diff}, `HLMC_DT_UNIT_CYC); // [R7]
   wire [19:0] ol_full = mul_unit(open_loop_period_code, `HLMC_OL_UNIT_CYC); // [R11]
   wire [19:0] ol_half = {1'b0, ol_full[19:1]};
   wire [19:0] fb_lim = fb_half - 20'h00001;
   wire [19:0] ol_lim = (ol_half == 20'h0) ? 20'h0 : ol_half - 20'h00001;

   wire driving = (state == ST_DRIVE) | (state == ST_BRAKE);
   wire pwm_wrap = (pwm_cnt == PWM_LAST);
   wire zc_hit = (bs_sync ^ bs_prev) & bv_sync;
   wire closed = cl_mode & ~latched;
   wire [7:0] target = scale8(amp, rated); // [R17]
   wire [10:0] brk_raw = {3'h0, target} * ({8'h0, brake_gain_ratio} + 11'h001);
   wire [31:0] dprod = {24'h0, lvl} * `HLMC_PWM_CYC;

   // Pin synchronisers; the first stage is never read by logic
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sd_meta <= 1'b0;
         sd_sync <= 1'b0;
         bs_meta <= 1'b0;
         bs_sync <= 1'b0;
         bv_meta <= 1'b0;
         bv_sync <= 1'b0;
         bs_prev <= 1'b0;
      end
      else
      begin
         sd_meta <= shutdown_n_pin;
         sd_sync <= sd_meta;
         bs_meta <= bemf_sign_pin;
         bs_sync <= bs_meta;
         bv_meta <= bemf_valid_pin;
         bv_sync <= bv_meta;
         bs_prev <= bs_sync; // Delayed sign, a toggle marks a crossing
      end
   end

   // Half-cycle boundary: carrier wrap for ERM, back-EMF edge, fallback timeout or open-loop timer
   always @*
   begin
      bound = 1'b0;
      good = 1'b0;
      bad = 1'b0;
      if (driving)
      begin
         if (!act_lra)
            bound = pwm_wrap;
         else if (cl_mode)
         begin
            if (zc_hit)
            begin
               bound = 1'b1; // [R2] [R3]
               good = 1'b1;
            end
            else if (half_tmr >= fb_lim)
            begin
               bound = 1'b1; // [R6] [R7]
               bad = 1'b1;
            end
         end
         else
            bound = (half_tmr >= ol_lim); // [R11]
      end
   end

   // Output level: boost and brake only in closed loop, clamp in every mode
   always @*
   begin
      if (state == ST_BRAKE)
         lvl = clamp8(brk_raw, clampv); // [R14] [R16] [R18]
      else if (!closed)
         lvl = clamp8({3'h0, target}, clampv); // [R10]
      else if (act_lra && !synced)
         lvl = clampv; // [R6]
      else if (halves < BOOST_N)
         lvl = clamp8({1'b0, target, 2'b00}, clampv); // [R14] [R15] [R18]
      else
         lvl = clamp8({3'h0, target}, clampv); // [R17] [R18]
   end

   // Configuration registers; shutdown clears them like a reset
   always @(posedge aclk)
   begin
      if (!aresetn || !sd_sync)
      begin
         ctrl <= `HLMC_CTRL_RST; // [R19]
         drive <= `HLMC_DRV_RST;
         level <= `HLMC_LVL_RST;
      end
      else if (wr_go)
      begin
         if (awaddr == `HLMC_OFS_CTRL)
            ctrl <= merge(ctrl, wdata, wstrb) & `HLMC_CTRL_MASK;
         if (awaddr == `HLMC_OFS_DRIVE)
            drive <= merge(drive, wdata, wstrb) & `HLMC_DRV_MASK;
         if (awaddr == `HLMC_OFS_LEVEL)
            level <= merge(level, wdata, wstrb) & `HLMC_LVL_MASK;
      end
   end

   // Write response
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= `HLMC_RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? `HLMC_RESP_OKAY : `HLMC_RESP_SLVERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // Read decode
   always @*
   begin
      rd_val = 32'h0;
      rd_err = 1'b0;
      case (araddr)
         `HLMC_OFS_CTRL: rd_val = ctrl;
         `HLMC_OFS_DRIVE: rd_val = drive;
         `HLMC_OFS_LEVEL: rd_val = level;
         `HLMC_OFS_STATUS: rd_val = {26'h0, synced & (state == ST_DRIVE),
            closed, state == ST_BRAKE, latched, synced, state != ST_IDLE};
         `HLMC_OFS_PERIOD: rd_val = {11'h0, period}; // [R5]
         default: rd_err = 1'b1;
      endcase
   end

   // Read data is registered with its response
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `HLMC_RESP_OKAY;
      end
      else if (ar_go)
      begin
         rvalid <= 1'b1;
         rdata <= rd_val;
         rresp <= rd_err ? `HLMC_RESP_SLVERR : `HLMC_RESP_OKAY;
      end
      else if (rready)
         rvalid <= 1'b0;
   end

   // Playback sequencer and resonance tracking
   always @(posedge aclk)
   begin
      if (!aresetn || !sd_sync)
      begin
         state <= ST_IDLE; // [R19]
         wait_cnt <= 16'h0;
         half_tmr <= 20'h0;
         period <= 21'h0;
         halves <= 8'h0;
         brk_cnt <= 8'h0;
         unsync_cnt <= 3'h0;
         pol <= 1'b1;
         synced <= 1'b0;
         latched <= 1'b0;
         cl_mode <= 1'b1;
         act_lra <= 1'b0;
      end
      else
      begin
         // Latch is released by clearing its enable, or by reset or shutdown
         if (!latch_open_loop_enable)
            latched <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               half_tmr <= 20'h0;
               halves <= 8'h0;
               unsync_cnt <= 3'h0;
               synced <= 1'b0;
               pol <= 1'b1;
               cl_mode <= ~latched;
               act_lra <= actuator_type_select; // [R1]
               wait_cnt <= 16'h0;
               if (go)
                  state <= ST_WAIT;
            end
            ST_WAIT:
            begin
               wait_cnt <= wait_cnt + 16'h0001;
               if (!go)
                  state <= ST_IDLE;
               else if (wait_cnt == START_LAST)
                  state <= ST_DRIVE; // [R12]
            end
            default:
            begin
               half_tmr <= bound ? 20'h0 : half_tmr + 20'h00001;
               // Tracking uses only the edge timer, never the level scaling
               if (good)
                  period <= {half_tmr + 20'h00001, 1'b0}; // [R2] [R3] [R4] [R5]
               if (bound)
               begin
                  if (act_lra)
                     pol <= ~pol;
                  if (halves != 8'hff)
                     halves <= halves + 8'h01;
                  cl_mode <= ~latched; // [R20]
               end
               if (good)
               begin
                  synced <= 1'b1; // [R6]
                  unsync_cnt <= 3'h0;
               end
               if (bad)
               begin
                  synced <= 1'b0;
                  if (unsync_cnt != 3'h7)
                     unsync_cnt <= unsync_cnt + 3'h1;
                  if (latch_open_loop_enable && unsync_cnt >= {1'b0, unsync_cycle_limit})
                     latched <= 1'b1; // [R8] [R9]
               end
               if (state == ST_DRIVE && !go && bound)
               begin
                  // Braking only when the loop is closed
                  brk_cnt <= BRAKE_N;
                  state <= closed ? ST_BRAKE : ST_IDLE; // [R10] [R14] [R20]
               end
               else if (state == ST_BRAKE && bound)
               begin
                  brk_cnt <= brk_cnt - 8'h01;
                  if (brk_cnt <= 8'h01)
                     state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // PWM carrier; duty reloads at wrap so a period is never cut short
   always @(posedge aclk)
   begin
      if (!aresetn || !sd_sync)
      begin
         pwm_cnt <= 11'h0;
         duty <= 11'h0;
         out_p <= 1'b0;
         out_n <= 1'b0;
      end
      else
      begin
         pwm_cnt <= pwm_wrap ? 11'h0 : pwm_cnt + 11'h001; // [R13]
         if (pwm_wrap)
            duty <= dprod[18:8];
         out_p <= driving & (pwm_cnt < duty) & (pol ^ (state == ST_BRAKE)); // [R13]
         out_n <= driving & (pwm_cnt < duty) & ~(pol ^ (state == ST_BRAKE)); // [R13]
      end
   end

endmodule // hlmc_top

`default_nettype wire

//--- verification/hlmc_act_model.sv
// Behavioural vibration actuator returning back-EMF crossings
`timescale 1ns/1ps
`default_nettype none
module hlmc_act_model (
   // Clock and scenario controls
   input wire logic aclk,
   input wire logic [15:0] half,
   input wire logic moving,
   // Back-EMF sense lines
   output var logic bemf_sign_pin,
   output var logic bemf_valid_pin
);
   logic [15:0] cnt;
   // Crossing every half period while moving; at rest the sign is noise, never a held level
   always @(posedge aclk)
   begin
      bemf_valid_pin <= moving;
      cnt <= (!moving || cnt >= half - 16'h1) ? 16'h0 : cnt + 16'h1;
      if (!moving || cnt >= half - 16'h1)
         bemf_sign_pin <= ~bemf_sign_pin;
   end
   // Start at rest
   initial
   begin
      cnt = 16'h0;
      bemf_sign_pin = 1'b0;
      bemf_valid_pin = 1'b0;
   end
endmodule // hlmc_act_model
`default_nettype wire

//--- verification/hlmc_top_props.sv
// Port-level checks for the haptic loop mode control block
`timescale 1ns/1ps
`default_nettype none
module hlmc_props (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   input wire logic wvalid,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic [7:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // Pins
   input wire logic shutdown_n_pin,
   input wire logic out_p,
   input wire logic out_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Pin low long enough to pass the synchronisers and reach the outputs
   sequence s_off;
      !shutdown_n_pin [*6];
   endsequence
   sequence s_rd_bad;
      arvalid && !rvalid && araddr > 8'h13;
   endsequence
   // Drive shape
   drive_excl_a: assert property (!(out_p && out_n)) else $error("both outputs high");
   p_gap_a: assert property ($fell(out_p) |=> !out_p [*7]) else $error("short gap out_p");
   n_gap_a: assert property ($fell(out_n) |=> !out_n [*7]) else $error("short gap out_n");
   off_quiet_a: assert property (s_off |=> !out_p && !out_n)
      else $error("drive during shutdown");
   // Bus answers
   wr_answer_a: assert property (awvalid && wvalid && !bvalid |=> bvalid)
      else $error("write not answered");
   b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   rd_answer_a: assert property (arvalid && !rvalid |=> rvalid) else $error("no read answer");
   r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   bad_addr_a: assert property (s_rd_bad |=> rresp == 2'h2 && rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule // hlmc_props
bind hlmc_top hlmc_props props_u (.aclk, .aresetn, .awvalid, .wvalid, .bvalid, .bready, .bresp,
   .arvalid, .araddr, .rvalid, .rready, .rdata, .rresp, .shutdown_n_pin, .out_p, .out_n);
`default_nettype wire

//--- verification/test_haptic_loop_mode_control.sv
// Self-checking bench for the haptic loop mode control block
`timescale 1ns/1ps
`default_nettype none
module test_haptic_loop_mode_control;
   // Short start delay keeps the run brief
   localparam int ST = 400;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, shutdown_n_pin, moving;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, d;
   logic [3:0] wstrb;
   logic [1:0] r;
   logic [15:0] half;
   wire logic awready, wready, bvalid, arready, rvalid, bemf_sign_pin, bemf_valid_pin;
   wire logic out_p, out_n;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   int bad_count = 0;
   int n_tests = 0;
   int hi, lo, h;
   hlmc_top #(.START_CYC(ST)) dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .shutdown_n_pin, .bemf_sign_pin, .bemf_valid_pin, .out_p, .out_n);
   hlmc_act_model act_u (.aclk, .half, .moving, .bemf_sign_pin, .bemf_valid_pin);
   // 40 MHz clock
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      begin
         n_tests++;
         if (got !== want)
         begin
            bad_count++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
         end
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Address and data go together; response is taken late on purpose to stall the slave
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      begin
         awaddr <= a;
         wdata <= v;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         do @(posedge aclk); while (!awready);
         awvalid <= 1'b0;
         wvalid <= 1'b0;
         do @(posedge aclk); while (!bvalid);
         bready <= 1'b1;
         @(posedge aclk);
         r = bresp;
         bready <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a);
      begin
         araddr <= a;
         arvalid <= 1'b1;
         do @(posedge aclk); while (!arready);
         arvalid <= 1'b0;
         do @(posedge aclk); while (!rvalid);
         rready <= 1'b1;
         @(posedge aclk);
         d = rdata;
         r = rresp;
         rready <= 1'b0;
      end
   endtask
   // Low time before the next out_p pulse, then its high time
   task automatic meas;
      begin
         for (lo = 0; !out_p; lo++)
            @(posedge aclk);
         for (hi = 0; out_p; hi++)
            @(posedge aclk);
      end
   endtask
   task automatic t_regs;
      begin
         rd(8'h00);
         chk(d, 32'h0);
         rd(8'h04);
         chk(d, 32'h00100a29);
         rd(8'h08);
         chk(d, 32'h00c08000);
         wr(8'h00, 32'hffffffee);
         rd(8'h00);
         chk(d, 32'h0000000e);
         wr(8'h00, 32'h0);
         wr(8'h40, 32'h1);
         chk(r, 2'h2);
         rd(8'h40);
         chk(r, 2'h2);
         $display("regs done");
      end
   endtask
   task automatic t_erm;
      begin
         wr(8'h08, 32'h00c080ff);
         wr(8'h00, 32'h00000010);
         meas();
         chk(lo >= ST - 4 && lo <= ST + 1960, 1'h1);
         chk(hi > 975 && hi <= 1463, 1'h1);
         repeat (6) meas();
         h = hi;
         meas();
         chk(h + lo, 1951);
         chk(hi, 975);
         wr(8'h00, 32'h0);
         for (lo = 0; !out_n && lo < 4000; lo++)
            @(posedge aclk);
         chk(out_n, 1'h1);
         wt(8300);
         rd(8'h0c);
         chk({d[0], out_p, out_n}, 3'h0);
         $display("erm done");
      end
   endtask
   task automatic t_lra;
      begin
         moving <= 1'b1;
         wr(8'h04, 32'h00100102);
         wr(8'h00, 32'h00000011);
         wt(ST + 3500);
         rd(8'h0c);
         chk(d[1], 1'h1);
         wt(3000);
         rd(8'h10);
         chk(d > 5996 && d < 6004, 1'h1);
         half <= 16'h9c4;
         wt(6000);
         rd(8'h10);
         chk(d > 4996 && d < 5004, 1'h1);
         moving <= 1'b0;
         wt(8500);
         rd(8'h0c);
         chk(d[1:0], 2'h1);
         moving <= 1'b1;
         wt(5000);
         rd(8'h0c);
         chk(d[1:0], 2'h3);
         wr(8'h00, 32'h1);
         wt(14000);
         $display("lra done");
      end
   endtask
   task automatic t_latch;
      begin
         moving <= 1'b0;
         // Open-loop code 1 makes each half period one carrier period
         wr(8'h04, 32'h00100101);
         wr(8'h00, 32'h00000017);
         wt(ST + 6000);
         rd(8'h0c);
         chk(d[2], 1'h0);
         wt(4000);
         rd(8'h0c);
         chk(d[4:2], 3'h1);
         // First out_p rise after out_n, then the next such rise: one full period
         for (h = 0; !out_n && h < 9000; h++)
            @(posedge aclk);
         for (h = 0; !out_p && h < 9000; h++)
            @(posedge aclk);
         for (lo = 0; !out_n && lo < 9000; lo++)
            @(posedge aclk);
         for (hi = 0; !out_p && hi < 9000; hi++)
            @(posedge aclk);
         chk(lo + hi, 3902);
         wr(8'h00, 32'h7);
         wt(4100);
         rd(8'h0c);
         chk(d[3:0], 4'h4);
         wr(8'h00, 32'h00000011);
         wt(ST + 2000);
         shutdown_n_pin <= 1'b0;
         wt(10);
         shutdown_n_pin <= 1'b1;
         wt(4);
         rd(8'h00);
         chk(d, 32'h0);
         chk({out_p, out_n}, 2'h0);
         $display("latch done");
      end
   endtask
   task automatic test_done;
      begin
         $display("checks %0d mismatches %0d", n_tests, bad_count);
         if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // Main sequence; host selects the actuator type before each play
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, moving} = 7'h0;
      shutdown_n_pin = 1'b1;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
      half = 16'hbb8;
      wt(5);
      aresetn <= 1'b1;
      wt(3);
      t_regs();
      t_erm();
      t_lra();
      t_latch();
      test_done();
   end
   // Watchdog only about a tenth beyond the expected run length
   initial
   begin
      wt(100000);
      bad_count++;
      test_done();
   end
endmodule // test_haptic_loop_mode_control
`default_nettype wire
